// [hdl/dcw_pkg.sv]
// Package of constants and types for the control word upper-bit decoder.
package dcw_pkg;
  // ********************************************************************
  // Control word bit positions and widths
  // ********************************************************************
  localparam int FSEL_LO_BIT    = 16;
  localparam int FSEL_HI_BIT    = 17;
  localparam int MSEL_LO_BIT    = 18;
  localparam int MSEL_HI_BIT    = 19;
  localparam int SPSEL_LO_BIT   = 20;
  localparam int SPSEL_HI_BIT   = 21;
  localparam int SYNC_EN_BIT    = 22;
  localparam int FLY_EN_BIT     = 23;
  localparam int DROOP_EN_BIT   = 24;
  localparam int CTRL_EN_BIT    = 25;
  localparam int CW_WIDTH       = 32;
  localparam int DATA_WIDTH     = 16;
  localparam int SCALE_WIDTH    = 16;

  // ********************************************************************
  // Operating states, control types and synchronizing modes
  // ********************************************************************
  localparam logic [9:0] OPST_READY_TO_POWER = 10'd9;
  localparam logic [9:0] OPST_PRECHARGING    = 10'd10;
  localparam logic [9:0] OPST_READY          = 10'd11;
  localparam logic [2:0] CTYPE_0 = 3'h0;
  localparam logic [2:0] CTYPE_1 = 3'h1;
  localparam logic [2:0] CTYPE_2 = 3'h2;
  localparam logic [2:0] CTYPE_3 = 3'h3;
  localparam logic [2:0] CTYPE_4 = 3'h4;
  localparam logic [2:0] CTYPE_5 = 3'h5;
  localparam logic [1:0] SYNC_CONVERTER = 2'h1;
  localparam logic [1:0] SYNC_LINE      = 2'h2;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [1:0] SEL_RESET = 2'h0;

  // Sequencer of the motor set change, Gray coded.
  typedef enum logic [1:0]
  {
    DCW_MS_HOLD  = 2'b00,
    DCW_MS_APPLY = 2'b01
  } dcw_ms_state_t;
endpackage : dcw_pkg

// [hdl/dcw_sel2.sv]
// Two-bit set selector: builds an index and a one-hot set decode.
`timescale 1ns/1ps
`default_nettype none
module dcw_sel2
  import dcw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       bit_lo,
  input  wire logic       bit_hi,
  input  wire logic       load,
  output logic [1:0]      index,
  output logic [3:0]      onehot
);
  logic [1:0] sel_ff;
  logic [1:0] nxt_sel;
  logic [3:0] hot_ff;
  logic [3:0] nxt_hot;

  // ********************************************************************
  // Index and decode
  // ********************************************************************
  // Index is twice the high bit plus the low bit; exactly one set is hot.
  always_comb
  begin
    nxt_sel = sel_ff;
    if (load)
      nxt_sel = {bit_hi, bit_lo};
    nxt_hot = 4'h1 << nxt_sel;
  end

  // Registered so the selection outputs never glitch.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sel_ff <= SEL_RESET;
      hot_ff <= 4'h1;
    end
    else if (clk_en)
    begin
      sel_ff <= nxt_sel;
      hot_ff <= nxt_hot;
    end
  end

  assign index  = sel_ff;
  assign onehot = hot_ff;

  one_hot_a : assert property (@(posedge clk) disable iff (!rst_n)
    $onehot(onehot) && onehot[index])
    else $error("set decode is not one-hot on the index");
endmodule : dcw_sel2
`default_nettype wire

// [hdl/dcw_decode.sv]
// Decoder of the upper control word bits 16 to 25 of a drive.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Control bit 16 is the low bit of the function set selection.
// - Bits 16 and 17 form an index making exactly one of four function sets active.
// - Bits 18 and 19 form an index making exactly one of four motor sets active.
// - A motor set change takes effect only in operating states 009, 010 or 011.
// - Bit 20 is the low and bit 21 the high bit of the fixed setpoint selector.
// - The chosen fixed setpoint is a percentage of reference frequency or speed.
// - In converter sync mode 1, sync is on with bit 22, option fitted, control type 2.
// - In line sync mode 2, sync is on with bit 22, option fitted, control type 1 to 3.
// - Restart on the fly is enabled exactly while bit 23 is high.
// - Droop is on with bit 24, control type 3 or 4, nonzero scaling, pulses enabled.
// - With droop on, the scaled controller output is subtracted from the setpoint.
// - Speed controller output is released with bit 25, pulses on, control type 0, 4 or 5.
module dcw_decode
  import dcw_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  input  wire logic [dcw_pkg::CW_WIDTH-1:0] control_word,
  input  wire logic [9:0]                   operating_state,
  input  wire logic [2:0]                   control_type_setting,
  input  wire logic [1:0]                   sync_mode_setting,
  input  wire logic                         sync_option_fitted,
  input  wire logic                         pulses_enabled,
  input  wire logic                         fixed_ref_is_speed,
  input  wire logic [dcw_pkg::SCALE_WIDTH-1:0] droop_scaling_setting,
  input  wire logic signed [dcw_pkg::DATA_WIDTH-1:0] droop_source_setting,
  input  wire logic signed [dcw_pkg::DATA_WIDTH-1:0] speed_setpoint,
  input  wire logic [dcw_pkg::DATA_WIDTH-1:0] reference_frequency_setting,
  input  wire logic [dcw_pkg::DATA_WIDTH-1:0] reference_speed_setting,
  input  wire logic [dcw_pkg::DATA_WIDTH-1:0] fixed_percent_0,
  input  wire logic [dcw_pkg::DATA_WIDTH-1:0] fixed_percent_1,
  input  wire logic [dcw_pkg::DATA_WIDTH-1:0] fixed_percent_2,
  input  wire logic [dcw_pkg::DATA_WIDTH-1:0] fixed_percent_3,
  output logic [1:0]                        function_set_select,
  output logic [3:0]                        function_set_active,
  output logic [1:0]                        motor_set_select,
  output logic [3:0]                        motor_set_active,
  output logic [1:0]                        fixed_setpoint_select,
  output logic [dcw_pkg::DATA_WIDTH-1:0]    fixed_setpoint_value,
  output logic                              sync_enable,
  output logic                              fly_restart_enable,
  output logic                              droop_enable,
  output logic                              speed_ctrl_release,
  output logic signed [dcw_pkg::DATA_WIDTH-1:0] corrected_setpoint
);
  logic       motor_idle;
  logic       motor_change;
  logic [3:0] fixed_hot;
  logic [1:0] motor_idx;
  logic       sync_c;
  logic       droop_c;
  logic       ctrl_c;
  logic [DATA_WIDTH-1:0] fix_pct;
  logic [DATA_WIDTH-1:0] fix_ref;
  logic [DATA_WIDTH-1:0] fix_val;
  logic signed [DATA_WIDTH+SCALE_WIDTH:0] droop_prod;
  logic signed [DATA_WIDTH+SCALE_WIDTH+1:0] corr_wide;
  logic signed [DATA_WIDTH-1:0] corr_val;
  logic                  sync_ff, fly_ff, droop_ff, ctrl_ff;
  logic                  nxt_sync, nxt_fly, nxt_droop, nxt_ctrl;
  logic [DATA_WIDTH-1:0] fix_ff, nxt_fix;
  logic signed [DATA_WIDTH-1:0] corr_ff, nxt_corr;
  dcw_ms_state_t         ms_ff, nxt_ms;

  // ********************************************************************
  // Set selectors
  // ********************************************************************
  // Function sets follow bits 16 and 17 on every enabled edge, in any operating state.
  dcw_sel2 u_func
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .bit_lo (control_word[FSEL_LO_BIT]),
    .bit_hi (control_word[FSEL_HI_BIT]),
    .load   (1'b1),
    .index  (function_set_select),
    .onehot (function_set_active)
  );

  // Motor sets only reload in the idle-side states; elsewhere the old set holds.
  assign motor_idle = (operating_state == OPST_READY_TO_POWER) ||
                      (operating_state == OPST_PRECHARGING) ||
                      (operating_state == OPST_READY);
  assign motor_change = motor_idle &&
    ({control_word[MSEL_HI_BIT], control_word[MSEL_LO_BIT]} != motor_idx);

  dcw_sel2 u_motor
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .bit_lo (control_word[MSEL_LO_BIT]),
    .bit_hi (control_word[MSEL_HI_BIT]),
    .load   (motor_change),
    .index  (motor_idx),
    .onehot (motor_set_active)
  );
  assign motor_set_select = motor_idx;

  // Fixed setpoint selector, bit 20 least significant.
  dcw_sel2 u_fixed
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .bit_lo (control_word[SPSEL_LO_BIT]),
    .bit_hi (control_word[SPSEL_HI_BIT]),
    .load   (1'b1),
    .index  (fixed_setpoint_select),
    .onehot (fixed_hot)
  );

  // ********************************************************************
  // Motor set change tracker
  // ********************************************************************
  // Marks the cycle where a permitted change is being applied.
  always_comb
  begin
    nxt_ms = motor_change ? DCW_MS_APPLY : DCW_MS_HOLD;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ms_ff <= DCW_MS_HOLD;
    else if (clk_en)
      ms_ff <= nxt_ms;
  end

  // ********************************************************************
  // Enables and arithmetic
  // ********************************************************************
  // Qualified enables plus setpoint math; percentages are in 1/100 units.
  always_comb
  begin
    sync_c = 1'b0;
    if (sync_mode_setting == SYNC_CONVERTER)
      sync_c = control_word[SYNC_EN_BIT] && sync_option_fitted &&
               (control_type_setting == CTYPE_2);
    else if (sync_mode_setting == SYNC_LINE)
      sync_c = control_word[SYNC_EN_BIT] && sync_option_fitted &&
               ((control_type_setting == CTYPE_1) ||
                (control_type_setting == CTYPE_2) ||
                (control_type_setting == CTYPE_3));
    droop_c = control_word[DROOP_EN_BIT] && pulses_enabled &&
              (droop_scaling_setting != '0) &&
              ((control_type_setting == CTYPE_3) ||
               (control_type_setting == CTYPE_4));
    ctrl_c = control_word[CTRL_EN_BIT] && pulses_enabled &&
             ((control_type_setting == CTYPE_0) ||
              (control_type_setting == CTYPE_4) ||
              (control_type_setting == CTYPE_5));
    // Percentage of the chosen reference; 100 percent yields the reference.
    // The held selection is used, so a new selection reaches the value one
    // enabled edge after it shows on the select outputs.
    fix_pct = fixed_percent_0;
    if (fixed_hot[1])
      fix_pct = fixed_percent_1;
    else if (fixed_hot[2])
      fix_pct = fixed_percent_2;
    else if (fixed_hot[3])
      fix_pct = fixed_percent_3;
    fix_ref = fixed_ref_is_speed ? reference_speed_setting
                                 : reference_frequency_setting;
    fix_val = DATA_WIDTH'((32'(fix_pct) * 32'(fix_ref)) / 32'd100);
    // Scaling is Q8.8 so small droop gains are representable.
    droop_prod = droop_source_setting * $signed({1'b0, droop_scaling_setting});
    corr_wide = (DATA_WIDTH+SCALE_WIDTH+2)'(speed_setpoint) -
                (DATA_WIDTH+SCALE_WIDTH+2)'(droop_prod >>> 8);
    corr_val = droop_c ? DATA_WIDTH'(corr_wide) : speed_setpoint;
    nxt_sync  = sync_c;
    nxt_fly   = control_word[FLY_EN_BIT];
    nxt_droop = droop_c;
    nxt_ctrl  = ctrl_c;
    nxt_fix   = fix_val;
    nxt_corr  = corr_val;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_ff  <= 1'b0;
      fly_ff   <= 1'b0;
      droop_ff <= 1'b0;
      ctrl_ff  <= 1'b0;
      fix_ff   <= '0;
      corr_ff  <= '0;
    end
    else if (clk_en)
    begin
      sync_ff  <= nxt_sync;
      fly_ff   <= nxt_fly;
      droop_ff <= nxt_droop;
      ctrl_ff  <= nxt_ctrl;
      fix_ff   <= nxt_fix;
      corr_ff  <= nxt_corr;
    end
  end

  assign sync_enable          = sync_ff;
  assign fly_restart_enable   = fly_ff;
  assign droop_enable         = droop_ff;
  assign speed_ctrl_release   = ctrl_ff;
  assign fixed_setpoint_value = fix_ff;
  assign corrected_setpoint   = corr_ff;

  // ********************************************************************
  // Checks
  // ********************************************************************
  func_follow_a : assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> function_set_select ==
      $past({control_word[FSEL_HI_BIT], control_word[FSEL_LO_BIT]}))
    else $error("function set does not follow bits 16 and 17");
  motor_hold_a : assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !motor_idle) |=> $stable(motor_set_select))
    else $error("motor set changed outside idle states");
  motor_take_a : assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && motor_idle) |=> motor_set_select ==
      $past({control_word[MSEL_HI_BIT], control_word[MSEL_LO_BIT]}))
    else $error("motor set not taken in idle state");
  motor_apply_a : assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && motor_change) |=> (ms_ff == DCW_MS_APPLY) &&
      (motor_set_select != $past(motor_set_select)))
    else $error("permitted motor set change not applied");
  fixed_sel_a : assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> fixed_setpoint_select[0] == $past(control_word[SPSEL_LO_BIT]))
    else $error("fixed setpoint low bit wrong");
  sync_conv_a : assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && sync_mode_setting == SYNC_CONVERTER &&
     control_type_setting != CTYPE_2) |=> !sync_enable)
    else $error("converter sync enabled with wrong control type");
  sync_line_a : assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && sync_mode_setting == SYNC_LINE && sync_option_fitted &&
     control_word[SYNC_EN_BIT] && control_type_setting == CTYPE_3)
    |=> sync_enable)
    else $error("line sync not enabled");
  fly_follow_a : assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> fly_restart_enable == $past(control_word[FLY_EN_BIT]))
    else $error("restart on the fly does not follow bit 23");
  droop_gate_a : assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && (!pulses_enabled || droop_scaling_setting == '0))
    |=> !droop_enable)
    else $error("droop enabled without its conditions");
  droop_pass_a : assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !droop_c) |=> corrected_setpoint == $past(speed_setpoint))
    else $error("setpoint altered while droop is off");
  ctrl_gate_a : assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && control_word[CTRL_EN_BIT] && pulses_enabled &&
     control_type_setting == CTYPE_5) |=> speed_ctrl_release)
    else $error("speed controller not released");
  fixed_val_a : assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && fixed_percent_0 == 16'h0064 && fixed_hot[0] &&
     fixed_ref_is_speed) |=> fixed_setpoint_value == $past(reference_speed_setting))
    else $error("fixed setpoint not scaled to reference");
endmodule : dcw_decode
`default_nettype wire

// [bench/dcw_ctrl_model.sv]
// Model of the higher-level controller that writes the drive control word.
`timescale 1ns/1ps
`default_nettype none
module dcw_ctrl_model
(
  input  wire logic        clk,
  input  wire logic [1:0]  req_fsel,
  input  wire logic [1:0]  req_msel,
  input  wire logic [1:0]  req_spsel,
  input  wire logic [3:0]  req_bits,
  output logic [31:0]      control_word
);
  // ******************************************************************
  // Word assembly
  // ******************************************************************
  logic [21:0] junk_ff = 22'h0;

  // Bits outside 16 to 25 churn every cycle, so any leak shows at once.
  always_ff @(negedge clk)
  begin
    junk_ff <= junk_ff + 22'h13579B;
  end

  // Low bit of each pair sits at the lower position of the word.
  assign control_word = {junk_ff[21:16], req_bits[3], req_bits[2],
                         req_bits[1], req_bits[0], req_spsel,
                         req_msel, req_fsel, junk_ff[15:0]};
endmodule : dcw_ctrl_model
`default_nettype wire

// [bench/dcw_decode_tb_top.sv]
// Self-checking testbench of the control word upper-bit decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  error_cnt++; $display("BAD t=%0t got=%0h exp=%0h", $time, a, e); end end
module dcw_decode_tb_top;
  import dcw_pkg::*;
  typedef struct packed {
    logic [1:0] fs, ms, sp; logic [15:0] fv; logic sy, fl, dr, rl;
    logic [15:0] cs;
  } dcw_exp_t;
  // ******************************************************************
  // Stimulus signals and scoreboard
  // ******************************************************************
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, fitted, pulses, ref_sel;
  logic [1:0] req_fsel, req_msel, req_spsel, smode;
  logic [3:0] req_bits, f_act, m_act;
  logic [2:0] ctype;
  logic [9:0] op_state;
  logic [15:0] scale, ref_frq, ref_spd, pct [4], f_val;
  logic signed [15:0] src, spt, cset;
  logic [31:0] cw;
  logic [1:0] f_sel, m_sel, s_sel;
  logic sy, fl, dr, rl;
  int error_cnt = 0, total_checks = 0, seed_val;
  dcw_exp_t m, q [$];

  // Clock of 100 ns period.
  initial forever #50 clk = ~clk;

  dcw_ctrl_model dcw_ctrl_model_inst (.clk(clk), .req_fsel(req_fsel),
    .req_msel(req_msel), .req_spsel(req_spsel), .req_bits(req_bits),
    .control_word(cw));

  dcw_decode dcw_decode_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .control_word(cw), .operating_state(op_state),
    .control_type_setting(ctype), .sync_mode_setting(smode),
    .sync_option_fitted(fitted), .pulses_enabled(pulses),
    .fixed_ref_is_speed(ref_sel), .droop_scaling_setting(scale),
    .droop_source_setting(src), .speed_setpoint(spt),
    .reference_frequency_setting(ref_frq),
    .reference_speed_setting(ref_spd), .fixed_percent_0(pct[0]),
    .fixed_percent_1(pct[1]), .fixed_percent_2(pct[2]),
    .fixed_percent_3(pct[3]), .function_set_select(f_sel),
    .function_set_active(f_act), .motor_set_select(m_sel),
    .motor_set_active(m_act), .fixed_setpoint_select(s_sel),
    .fixed_setpoint_value(f_val), .sync_enable(sy),
    .fly_restart_enable(fl), .droop_enable(dr),
    .speed_ctrl_release(rl), .corrected_setpoint(cset));

  // Applies reset and enable at this falling edge and notes the result.
  task automatic step(input logic r, input logic en);
    dcw_exp_t n;
    logic [15:0] refv;
    logic dq;
    longint d;
    rst_n = r;
    clk_en = en;
    n = m;
    if (!r)
      n = '0;
    else if (en)
    begin
      n.fs = req_fsel;
      if (op_state inside {OPST_READY_TO_POWER, OPST_PRECHARGING,
                           OPST_READY})
        n.ms = req_msel;
      n.sp = req_spsel;
      refv = ref_sel ? ref_spd : ref_frq;
      // The value is built on the selection held before this edge.
      n.fv = 16'((32'(pct[m.sp]) * 32'(refv)) / 32'd100);
      n.sy = req_bits[0] & fitted & ((smode == 2'h1 && ctype == 3'h2) ||
             (smode == 2'h2 && ctype inside {3'h1, 3'h2, 3'h3}));
      n.fl = req_bits[1];
      dq = req_bits[2] & (ctype inside {3'h3, 3'h4}) & (scale != 0)
           & pulses;
      n.dr = dq;
      n.rl = req_bits[3] & pulses & (ctype inside {3'h0, 3'h4, 3'h5});
      d = longint'(src) * longint'(scale);
      n.cs = dq ? 16'(longint'(spt) - (d >>> 8)) : spt;
    end
    m = n;
    q.push_back(n);
  endtask : step

  // Draws legal values for every input; percentages stay within 100.
  task automatic rnd();
    {req_fsel, req_msel, req_spsel, req_bits} = 10'($urandom);
    {fitted, pulses, ref_sel, smode} = 5'($urandom);
    ctype = 3'($urandom_range(0, 5));
    op_state = 10'($urandom_range(8, 12));
    scale = ($urandom % 4 == 0) ? 16'h0000 : 16'($urandom_range(1, 512));
    src = 16'($urandom_range(0, 1023)) - 16'sh0200;
    spt = 16'($urandom_range(0, 16000)) - 16'sd8000;
    {ref_frq, ref_spd} = $urandom;
    foreach (pct[i]) pct[i] = 16'($urandom_range(0, 100));
  endtask : rnd

  task automatic report_and_stop();
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // ******************************************************************
  // Monitor: results settle just after each rising edge
  // ******************************************************************
  initial forever
  begin
    dcw_exp_t e;
    @(posedge clk);
    #1;
    if (q.size() > 0)
    begin
      e = q.pop_front();
      `CHK(f_sel, e.fs)
      `CHK(f_act, 4'h1 << e.fs)
      `CHK(m_sel, e.ms)
      `CHK(m_act, 4'h1 << e.ms)
      `CHK(s_sel, e.sp)
      `CHK(f_val, e.fv)
      `CHK({sy, fl, dr, rl}, {e.sy, e.fl, e.dr, e.rl})
      `CHK(rl, e.rl)
      `CHK(dr, e.dr)
      `CHK(cset, e.cs)
    end
  end

  // Watchdog; the run needs about 440 cycles.
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    seed_val = $urandom(32'h3DBB);
    rnd();
    m = '0;
    repeat (10)
    begin
      @(negedge clk);
      step(1'b0, 1'b1);
    end
    // Idle state accepts a motor set change, state 5 refuses one.
    @(negedge clk);
    {req_fsel, req_msel, op_state} = {2'h2, 2'h1, 10'd11};
    step(1'b1, 1'b1);
    @(negedge clk);
    {req_msel, op_state} = {2'h3, 10'd5};
    step(1'b1, 1'b1);
    // A frozen clock enable must hold every output.
    @(negedge clk);
    req_fsel = 2'h1;
    step(1'b1, 1'b0);
    // Every control type against every sync mode with all bits set.
    for (int c = 0; c < 6; c++)
      for (int s = 0; s < 4; s++)
      begin
        @(negedge clk);
        {ctype, smode, req_bits} = {3'(c), 2'(s), 4'hF};
        {fitted, pulses, scale} = {2'b11, 16'h0100};
        // Set 0 at full percent must give back the speed reference.
        {req_spsel, ref_sel, pct[0]} = {2'h0, 1'b1, 16'h0064};
        step(1'b1, 1'b1);
      end
    // Random traffic with enable gaps and one mid-run reset.
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clk);
      rnd();
      step(i != 200, ($urandom % 5) != 0);
    end
    repeat (2) @(posedge clk);
    #2;
    report_and_stop();
  end
endmodule : dcw_decode_tb_top
`default_nettype wire
